/* File: logic/invert_group_exec.sv */
// Decode and execute unit for invert, or-with-complement, negate and no-operation.
`timescale 1ns/1ps
module invert_group_exec (
  input  wire logic                       clock,
  input  wire logic                       rst_n,
  input  wire logic                       instr_valid,
  input  wire logic [31:0]                instr,
  input  wire logic                       instr_wide,
  input  wire logic                       cond_passed,
  input  wire logic                       in_conditional_block,
  input  wire logic                       carry_flag,
  input  wire logic [31:0]                opnd_data,
  input  wire logic [31:0]                src_data,
  output logic      [3:0]                 opnd_addr,
  output logic      [3:0]                 src_addr,
  output logic                            retire,
  output invert_group_pkg::op_kind_t      retired_op,
  output logic                            decode_miss,
  output logic                            unpredictable,
  output logic                            rd_we,
  output logic      [3:0]                 rd_addr,
  output logic      [31:0]                rd_data,
  output logic      [3:0]                 flags_we,
  output logic      [3:0]                 flags_value
);
  import invert_group_pkg::*;

  op_kind_t    op;
  shift_kind_t shift_kind;
  logic [5:0]  shift_amount;
  logic [4:0]  imm5;
  logic [1:0]  type_f;
  logic [3:0]  rd_num;
  logic [3:0]  opnd_num;
  logic [3:0]  src_num;
  logic        set_flags;
  logic        wide_imm_match;
  logic        wide_hint_match;
  logic [31:0] shifted;
  logic        shift_carry;
  logic [31:0] imm_value;
  logic        imm_carry;
  logic        imm_bad;
  logic        unsafe;
  logic [31:0] result;
  logic        result_carry;
  logic        result_overflow;
  logic [32:0] negate_sum;
  logic        writes_reg;
  logic        commit;

  logic        retire_q;
  op_kind_t    retired_op_q;
  logic        miss_q;
  logic        unpred_q;
  logic        rd_we_q;
  logic [3:0]  rd_addr_q;
  logic [31:0] rd_data_q;
  logic [3:0]  flags_we_q;
  logic [3:0]  flags_value_q;

  // Shift fields of the wide register form.
  assign imm5   = {instr[IMM3_LSB +: 3], instr[IMM2_LSB +: 2]};
  assign type_f = instr[TYPE_LSB +: 2];

  // Wide immediate forms need bit 15 clear; the hint ignores its should-be bits.
  assign wide_imm_match = (instr[31:27] == WIDE_IMM_TOP_MATCH)
                       && (instr[25:21] == WIDE_ORN_IMM_MATCH)
                       && !instr[ZERO_BIT];
  assign wide_hint_match = (instr[31:20] == WIDE_HINT_TOP)
                        && (instr[15:14] == WIDE_HINT_LOW_TOP)
                        && !instr[12]
                        && (instr[10:0] == 11'h0); // [RQ10]

  // Register numbers come from different fields in the two widths.
  always_comb
  begin
    if (instr_wide)
    begin
      rd_num = instr[RD_LSB +: 4];
      opnd_num = instr[OPND_LSB +: 4];
      src_num  = instr[SRC_LSB +: 4];
    end
    else
    begin
      rd_num = {1'b0, instr[N_RD_LSB +: 3]};
      opnd_num = {1'b0, instr[N_RD_LSB +: 3]};
      src_num  = {1'b0, instr[N_SRC_LSB +: 3]};
    end
  end

  // The register file is read combinationally from the decoded fields.
  assign opnd_addr = opnd_num;
  assign src_addr  = src_num;

  // Operation decode and flag-update enable for every recognised encoding.
  always_comb
  begin
    op        = op_none;
    set_flags = 1'b0;
    if (!instr_wide)
    begin
      if (instr[15:6] == NARROW_INVERT_MATCH)
      begin
        op        = op_invert_reg;
        set_flags = !in_conditional_block; // [RQ4]
      end
      else if (instr[15:6] == NARROW_NEGATE_MATCH)
      begin
        op        = op_negate;
        set_flags = !in_conditional_block; // [RQ8]
      end
      else if (instr[15:0] == NARROW_HINT_WORD)
      begin
        op = op_hint; // [RQ10]
      end
    end
    else
    begin
      if ((instr[31:21] == WIDE_INVERT_MATCH) && (opnd_num == REG_ONES))
      begin
        op        = op_invert_reg;
        set_flags = instr[SETF_BIT]; // [RQ5]
      end
      else if (wide_imm_match)
      begin
        // An all-ones first operand field turns the instruction into an immediate invert.
        op        = (opnd_num == REG_ONES) ? op_invert_imm : op_or_compl_imm; // [RQ12]
        set_flags = instr[SETF_BIT];
      end
      else if (wide_hint_match)
      begin
        op = op_hint; // [RQ10]
      end
    end
  end

  // Shift decode: narrow forms shift by nothing, wide forms decode type and amount.
  always_comb
  begin
    shift_kind   = shift_lsl;
    shift_amount = 6'h0; // [RQ7]
    if (instr_wide)
    begin
      unique case (type_f)
        2'h0:
        begin
          shift_kind   = shift_lsl;
          shift_amount = {1'b0, imm5};
        end
        2'h1:
        begin
          shift_kind   = shift_lsr;
          shift_amount = (imm5 == 5'h0) ? SHIFT_FULL : {1'b0, imm5};
        end
        2'h2:
        begin
          shift_kind   = shift_asr;
          shift_amount = (imm5 == 5'h0) ? SHIFT_FULL : {1'b0, imm5};
        end
        2'h3:
        begin
          shift_kind   = (imm5 == 5'h0) ? shift_rrx : shift_ror;
          shift_amount = (imm5 == 5'h0) ? 6'h1 : {1'b0, imm5};
        end
      endcase
    end
  end

  // The source register goes through the shifter with the current carry.
  operand_shifter u_shifter (
    .value     (src_data),
    .kind      (shift_kind),
    .amount    (shift_amount),
    .carry_in  (carry_flag),
    .result    (shifted),
    .carry_out (shift_carry)
  ); // [RQ3]

  // The modified immediate is assembled from the i, imm3 and imm8 fields.
  modified_immediate_expander u_expander (
    .imm12       ({instr[I_BIT], instr[IMM3_LSB +: 3], instr[7:0]}),
    .carry_in    (carry_flag),
    .value       (imm_value),
    .carry_out   (imm_carry),
    .bad_pattern (imm_bad)
  ); // [RQ14]

  // Register choices and immediate patterns that have no defined result.
  always_comb
  begin
    unsafe = 1'b0;
    unique case (op)
      op_invert_reg:
        unsafe = instr_wide && ((rd_num == REG_SP) || (rd_num == REG_PC)
                             || (src_num == REG_SP) || (src_num == REG_PC)
                             || instr[ZERO_BIT]); // [RQ6]
      op_invert_imm:
        unsafe = (rd_num == REG_SP) || (rd_num == REG_PC) || imm_bad;
      op_or_compl_imm:
        unsafe = (rd_num == REG_SP) || (rd_num == REG_PC)
              || (opnd_num == REG_SP) || imm_bad; // [RQ13]
      default:
        unsafe = 1'b0;
    endcase
  end

  // Zero minus the source, done as zero plus the complement plus one.
  assign negate_sum = {1'b0, ~src_data} + 33'h1;

  // Result, carry and overflow for each operation.
  always_comb
  begin
    result          = 32'h0;
    result_carry    = carry_flag;
    result_overflow = 1'b0;
    unique case (op)
      op_invert_reg:
      begin
        result       = ~shifted; // [RQ1]
        result_carry = shift_carry;
      end
      op_invert_imm:
      begin
        result       = ~imm_value; // [RQ15]
        result_carry = imm_carry;
      end
      op_or_compl_imm:
      begin
        result       = opnd_data | ~imm_value; // [RQ11]
        result_carry = imm_carry;
      end
      op_negate:
      begin
        result          = negate_sum[31:0]; // [RQ8]
        result_carry    = negate_sum[32];
        result_overflow = src_data[SIGN_BIT] & negate_sum[SIGN_BIT];
      end
      default:
      begin
        result = 32'h0; // [RQ9]
      end
    endcase
  end

  // Only a passed condition and a defined encoding let an operation write.
  assign writes_reg = (op != op_none) && (op != op_hint); // [RQ9]
  assign commit     = instr_valid && cond_passed && !unsafe && writes_reg; // [RQ16]

  // Every recognised instruction retires, whether or not it takes effect.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      retire_q     <= 1'b0;
      retired_op_q <= op_none;
      miss_q       <= 1'b0;
      unpred_q     <= 1'b0;
    end
    else
    begin
      retire_q     <= instr_valid && (op != op_none); // [RQ16]
      retired_op_q <= instr_valid ? op : op_none;
      miss_q       <= instr_valid && (op == op_none);
      unpred_q     <= instr_valid && unsafe;
    end
  end

  // Destination register write port.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_we_q   <= 1'b0;
      rd_addr_q <= 4'h0;
      rd_data_q <= RESULT_RESET;
    end
    else
    begin
      rd_we_q <= commit;
      if (commit)
      begin
        rd_addr_q <= rd_num;
        rd_data_q <= result;
      end
    end
  end

  // Flag write port in N, Z, C, V order; V is only written by the negate alias.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      flags_we_q    <= FLAGS_RESET;
      flags_value_q <= FLAGS_RESET;
    end
    else
    begin
      if (commit && set_flags)
      begin
        flags_we_q    <= {3'h7, op == op_negate}; // [RQ2]
        flags_value_q <= {result[SIGN_BIT], result == 32'h0, result_carry,
                          result_overflow}; // [RQ2]
      end
      else
      begin
        flags_we_q    <= 4'h0;
        flags_value_q <= FLAGS_RESET;
      end
    end
  end

  // Outputs come straight from their registers.
  assign retire        = retire_q;
  assign retired_op    = retired_op_q;
  assign decode_miss   = miss_q;
  assign unpredictable = unpred_q;
  assign rd_we         = rd_we_q;
  assign rd_addr       = rd_addr_q;
  assign rd_data       = rd_data_q;
  assign flags_we      = flags_we_q;
  assign flags_value   = flags_value_q;

endmodule

/* File: logic/invert_group_pkg.sv */
// Constants, field positions and enumerations shared by the invert/or-complement group.
// Summary of operation
// (RQ1) Register invert writes the complement of the optionally shifted source register.
// (RQ2) Flag update sets N from bit 31, Z on zero, C from shifter; V unchanged.
// (RQ3) Source register passes the shifter with decoded type, amount and current carry.
// (RQ4) Narrow register invert updates flags only outside a conditional-execution block.
// (RQ5) Wide register invert updates flags exactly when its flag-update bit is one.
// (RQ6) Wide register invert with destination or source 13 or 15 is unpredictable.
// (RQ7) Narrow register invert uses logical left by zero; only wide form carries shifts.
// (RQ8) Negate alias is flag-setting reverse subtraction of source from zero into destination.
// (RQ9) No-operation hint, both widths, changes no register, flag or memory state.
// (RQ10) No-operation encodings need only the fixed opcode pattern recognised.
// (RQ11) Or-with-complement immediate writes first operand OR complement of expanded immediate.
// (RQ12) Or-with-complement immediate with first operand field all ones decodes as invert immediate.
// (RQ13) Or-with-complement immediate is unpredictable for destination 13/15 or first operand 13.
// (RQ14) The 12-bit modified immediate expands to 32 bits plus carry, using current carry.
// (RQ15) Immediate invert writes complement of expanded immediate; carry comes from expansion.
// (RQ16) Nothing takes effect unless the condition check passes; the instruction still retires.
package invert_group_pkg;

  localparam int unsigned DATA_W = 32;
  localparam int unsigned REG_W  = 4;

  // Operation classes produced by the decoder.
  typedef enum logic [2:0] {
    op_none,
    op_invert_reg,
    op_invert_imm,
    op_or_compl_imm,
    op_negate,
    op_hint
  } op_kind_t;

  // Shift kinds understood by the shifter.
  typedef enum logic [2:0] {
    shift_lsl,
    shift_lsr,
    shift_asr,
    shift_ror,
    shift_rrx
  } shift_kind_t;

  // Fixed opcode patterns.
  localparam logic [9:0]  NARROW_INVERT_MATCH = 10'h10f;
  localparam logic [9:0]  NARROW_NEGATE_MATCH = 10'h109;
  localparam logic [15:0] NARROW_HINT_WORD    = 16'hbf00;
  localparam logic [10:0] WIDE_INVERT_MATCH   = 11'h753;
  localparam logic [4:0]  WIDE_IMM_TOP_MATCH  = 5'h1e;
  localparam logic [4:0]  WIDE_ORN_IMM_MATCH  = 5'h03;
  localparam logic [11:0] WIDE_HINT_TOP       = 12'hf3a;
  localparam logic [1:0]  WIDE_HINT_LOW_TOP   = 2'h2;

  // Field positions of the wide forms (first halfword in bits 31:16).
  localparam int unsigned I_BIT      = 26;
  localparam int unsigned SETF_BIT   = 20;
  localparam int unsigned OPND_LSB   = 16;
  localparam int unsigned ZERO_BIT   = 15;
  localparam int unsigned IMM3_LSB   = 12;
  localparam int unsigned RD_LSB     = 8;
  localparam int unsigned IMM2_LSB   = 6;
  localparam int unsigned TYPE_LSB   = 4;
  localparam int unsigned SRC_LSB    = 0;
  // Field positions of the narrow forms.
  localparam int unsigned N_SRC_LSB  = 3;
  localparam int unsigned N_RD_LSB   = 0;
  localparam int unsigned SIGN_BIT   = 31;

  // Register numbers with special meaning.
  localparam logic [3:0] REG_SP   = 4'hd;
  localparam logic [3:0] REG_PC   = 4'hf;
  localparam logic [3:0] REG_ONES = 4'hf;

  // Shift amount used when a zero field means a full-width shift.
  localparam logic [5:0] SHIFT_FULL = 6'h20;

  // Reset values of the result registers.
  localparam logic [31:0] RESULT_RESET = 32'h0;
  localparam logic [3:0]  FLAGS_RESET  = 4'h0;

endpackage

/* File: logic/modified_immediate_expander.sv */
// Expands a 12-bit modified immediate into a 32-bit constant and a carry-out.
`timescale 1ns/1ps
module modified_immediate_expander (
  input  wire logic [11:0] imm12,
  input  wire logic        carry_in,
  output logic      [31:0] value,
  output logic             carry_out,
  output logic             bad_pattern
);

  logic [7:0]  imm8;
  logic [31:0] unrotated;
  logic [63:0] rotated;

  // The rotated form is an eight-bit value with a forced top bit.
  assign imm8      = imm12[7:0];
  assign unrotated = {24'h0, 1'b1, imm12[6:0]};
  assign rotated   = {unrotated, unrotated} >> imm12[11:7];

  // A replicated pattern built from a zero byte is an illegal encoding.
  assign bad_pattern = (imm12[11:10] == 2'h0) && (imm12[9:8] != 2'h0) && (imm8 == 8'h0);

  // Replicated patterns keep the incoming carry, rotated ones take bit 31.
  always_comb
  begin
    value     = rotated[31:0];
    carry_out = rotated[31];
    if (imm12[11:10] == 2'h0)
    begin
      carry_out = carry_in;
      unique case (imm12[9:8])
        2'h0: value = {24'h0, imm8};
        2'h1: value = {8'h0, imm8, 8'h0, imm8};
        2'h2: value = {imm8, 8'h0, imm8, 8'h0};
        2'h3: value = {4{imm8}};
      endcase
    end
  end

endmodule

/* File: logic/operand_shifter.sv */
// Barrel shifter returning the shifted value and its carry-out.
`timescale 1ns/1ps
module operand_shifter (
  input  wire logic [31:0]                 value,
  input  wire invert_group_pkg::shift_kind_t kind,
  input  wire logic [5:0]                  amount,
  input  wire logic                        carry_in,
  output logic      [31:0]                 result,
  output logic                             carry_out
);
  import invert_group_pkg::*;

  logic [32:0] lsl_t;
  logic [32:0] lsr_t;
  logic [32:0] asr_t;
  logic [63:0] ror_t;

  // The logical and arithmetic shifts keep the last bit shifted out in an extra position.
  assign lsl_t = {1'b0, value} << amount;
  assign lsr_t = {value, 1'b0} >> amount;
  assign asr_t = 33'($signed({value, 1'b0}) >>> amount);
  assign ror_t = {value, value} >> amount[4:0];

  // Except for rrx, a zero amount passes the value and the incoming carry through untouched.
  always_comb
  begin
    result    = value;
    carry_out = carry_in;
    if (kind == shift_rrx)
    begin
      result    = {carry_in, value[31:1]};
      carry_out = value[0];
    end
    else if (amount != 6'h0)
    begin
      unique case (kind)
        shift_lsl:
        begin
          result    = lsl_t[31:0];
          carry_out = lsl_t[32];
        end
        shift_lsr:
        begin
          result    = lsr_t[32:1];
          carry_out = lsr_t[0];
        end
        shift_asr:
        begin
          result    = asr_t[32:1];
          carry_out = asr_t[0];
        end
        default:
        begin
          result    = ror_t[31:0];
          carry_out = ror_t[31];
        end
      endcase
    end
  end

endmodule

/* File: testbench/invert_group_exec_sva.sv */
// Concurrent checks on the ports of the invert group unit.
`timescale 1ns/1ps
module invert_group_exec_sva (
  input wire logic                       clock,
  input wire logic                       rst_n,
  input wire logic                       instr_valid,
  input wire logic [31:0]                instr,
  input wire logic                       instr_wide,
  input wire logic                       cond_passed,
  input wire logic                       in_conditional_block,
  input wire logic                       carry_flag,
  input wire logic [31:0]                opnd_data,
  input wire logic [31:0]                src_data,
  input wire logic [3:0]                 opnd_addr,
  input wire logic [3:0]                 src_addr,
  input wire logic                       retire,
  input wire invert_group_pkg::op_kind_t retired_op,
  input wire logic                       decode_miss,
  input wire logic                       unpredictable,
  input wire logic                       rd_we,
  input wire logic [3:0]                 rd_addr,
  input wire logic [31:0]                rd_data,
  input wire logic [3:0]                 flags_we,
  input wire logic [3:0]                 flags_value
);
  import invert_group_pkg::*;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  // Decoded shapes of the accepted narrow invert and negate and the well-formed wide register invert.
  logic n_inv;
  logic n_neg;
  logic w_inv;
  assign n_inv = instr_valid && !instr_wide && instr[15:6] == NARROW_INVERT_MATCH && cond_passed;
  assign n_neg = instr_valid && !instr_wide && instr[15:6] == NARROW_NEGATE_MATCH && cond_passed;
  assign w_inv = instr_valid && instr_wide && instr[31:21] == WIDE_INVERT_MATCH
               && instr[19:16] == 4'hf && !instr[15] && cond_passed
               && instr[11:8] != 4'hd && instr[11:8] != 4'hf
               && instr[3:0] != 4'hd && instr[3:0] != 4'hf;

  // Request and quiet-answer steps.
  sequence outside_s;
    n_inv && !in_conditional_block;
  endsequence
  sequence no_write_s;
    !rd_we && flags_we == 4'h0;
  endsequence

  narrow_result_a: assert property (outside_s |=> rd_we && flags_we == 4'he
    && rd_data == ~$past(src_data) && flags_value[1] == $past(carry_flag))
    else $error("narrow invert result or carry wrong");
  inblock_flags_a: assert property (n_inv && in_conditional_block |=> rd_we && flags_we == 4'h0)
    else $error("flags written inside conditional block");
  wide_setf_a: assert property (w_inv |=> rd_we && flags_we[3] == $past(instr[20]))
    else $error("wide flag enable does not follow its bit");
  nz_flags_a: assert property (flags_we[3] |-> flags_value[3] == rd_data[31]
    && flags_value[2] == (rd_data == 32'h0))
    else $error("negative or zero flag wrong");
  v_negate_a: assert property (flags_we[0] |-> retired_op == op_negate)
    else $error("overflow written outside negate");
  unpred_quiet_a: assert property (unpredictable |-> retire ##0 no_write_s)
    else $error("unpredictable encoding wrote state");
  cond_fail_a: assert property (instr_valid && !cond_passed |=> no_write_s)
    else $error("write despite failed condition");
  hint_quiet_a: assert property (instr_valid && !instr_wide && instr[15:0] == NARROW_HINT_WORD
    |=> retire && retired_op == op_hint ##0 no_write_s)
    else $error("hint changed state");
  negate_calc_a: assert property (n_neg && !in_conditional_block
    |=> rd_we && flags_we == 4'hf && rd_data == 32'h0 - $past(src_data))
    else $error("negate result wrong");
  idle_quiet_a: assert property (!instr_valid |=> !retire && !decode_miss ##0 no_write_s)
    else $error("activity without instruction");
endmodule

/* File: testbench/tb_invert_group_exec.sv */
// Self-checking testbench for the invert group decode and execute unit.
`timescale 1ns/1ps
module tb_invert_group_exec;
  import invert_group_pkg::*;
  logic        clock;
  logic        rst_n;
  logic        instr_valid;
  logic [31:0] instr;
  logic        instr_wide;
  logic        cond_passed;
  logic        in_conditional_block;
  logic        carry_flag;
  logic [31:0] opnd_data;
  logic [31:0] src_data;
  logic [3:0]  opnd_addr;
  logic [3:0]  src_addr;
  logic        retire;
  op_kind_t    retired_op;
  logic        decode_miss;
  logic        unpredictable;
  logic        rd_we;
  logic [3:0]  rd_addr;
  logic [31:0] rd_data;
  logic [3:0]  flags_we;
  logic [3:0]  flags_value;
  int          n_mismatch;
  int          checks;

  invert_group_exec dut (.clock(clock), .rst_n(rst_n), .instr_valid(instr_valid), .instr(instr),
    .instr_wide(instr_wide), .cond_passed(cond_passed),
    .in_conditional_block(in_conditional_block), .carry_flag(carry_flag), .opnd_data(opnd_data),
    .src_data(src_data), .opnd_addr(opnd_addr), .src_addr(src_addr), .retire(retire),
    .retired_op(retired_op), .decode_miss(decode_miss), .unpredictable(unpredictable),
    .rd_we(rd_we), .rd_addr(rd_addr), .rd_data(rd_data), .flags_we(flags_we),
    .flags_value(flags_value));

  // Free-running core clock.
  always #5 clock = ~clock;

  // Counts a comparison and reports a mismatch.
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Presents one instruction and waits until its answer stands.
  task automatic send(input logic [31:0] w, input logic wd, input logic cp, input logic blk,
                      input logic c, input logic [31:0] a, input logic [31:0] b);
    instr_valid = 1'b1;
    instr = w;
    instr_wide = wd;
    cond_passed = cp;
    in_conditional_block = blk;
    carry_flag = c;
    opnd_data = a;
    src_data = b;
    @(posedge clock);
    #1;
  endtask

  // Compares the registered outputs of the answer cycle; write address and data only when a write is expected.
  task automatic chk_out(input logic r, input op_kind_t op, input logic we, input logic [3:0] ra,
                         input logic [31:0] d, input logic [3:0] fw, input logic [3:0] fv,
                         input logic up, input logic dm);
    cmp({31'h0, retire}, {31'h0, r});
    cmp({29'h0, retired_op}, {29'h0, op});
    cmp({31'h0, rd_we}, {31'h0, we});
    if (we)
    begin
      cmp({28'h0, rd_addr}, {28'h0, ra});
      cmp(rd_data, d);
    end
    cmp({28'h0, flags_we}, {28'h0, fw});
    cmp({28'h0, flags_value}, {28'h0, fv});
    cmp({31'h0, unpredictable}, {31'h0, up});
    cmp({31'h0, decode_miss}, {31'h0, dm});
  endtask

  // Lets one cycle pass with no instruction.
  task automatic idle;
    instr_valid = 1'b0;
    @(posedge clock);
    #1;
  endtask

  // Narrow register invert, back to back, outside and inside a conditional block.
  task automatic t_narrow;
    send(32'h43d7, 0, 1, 0, 1, 32'h0, 32'h0f0f00ff);
    cmp({28'h0, src_addr}, 32'h2);
    chk_out(1, op_invert_reg, 1, 4'h7, 32'hf0f0ff00, 4'he, 4'ha, 0, 0);
    send(32'h43d7, 0, 1, 1, 1, 32'h0, 32'hffffffff);
    chk_out(1, op_invert_reg, 1, 4'h7, 32'h0, 4'h0, 4'h0, 0, 0);
    send(32'h43d7, 0, 1, 0, 0, 32'h0, 32'hffffffff);
    chk_out(1, op_invert_reg, 1, 4'h7, 32'h0, 4'he, 4'h4, 0, 0);
  endtask

  // Wide register invert with a shift, flag bit both ways, forbidden registers.
  task automatic t_wide;
    send(32'hea7f0453, 1, 1, 0, 0, 32'h0, 32'h3);
    chk_out(1, op_invert_reg, 1, 4'h4, 32'hfffffffe, 4'he, 4'ha, 0, 0);
    send(32'hea6f0453, 1, 1, 0, 0, 32'h0, 32'h3);
    chk_out(1, op_invert_reg, 1, 4'h4, 32'hfffffffe, 4'h0, 4'h0, 0, 0);
    send(32'hea7f0434, 1, 1, 0, 1, 32'h0, 32'h3);
    chk_out(1, op_invert_reg, 1, 4'h4, 32'h7ffffffe, 4'he, 4'h2, 0, 0);
    send(32'hea7f0423, 1, 1, 0, 0, 32'h0, 32'h80000000);
    chk_out(1, op_invert_reg, 1, 4'h4, 32'h0, 4'he, 4'h6, 0, 0);
    send(32'hea7f1433, 1, 1, 0, 1, 32'h0, 32'h3);
    chk_out(1, op_invert_reg, 1, 4'h4, 32'hcfffffff, 4'he, 4'h8, 0, 0);
    send(32'hea7f0d53, 1, 1, 0, 0, 32'h0, 32'h3);
    chk_out(1, op_invert_reg, 0, 4'h0, 32'h0, 4'h0, 4'h0, 1, 0);
    send(32'hea7f045f, 1, 1, 0, 0, 32'h0, 32'h3);
    chk_out(1, op_invert_reg, 0, 4'h0, 32'h0, 4'h0, 4'h0, 1, 0);
  endtask

  // Immediate invert through the all-ones operand field, or-complement and its bad registers.
  task automatic t_imm;
    send(32'hf07f4200, 1, 1, 0, 0, 32'h0, 32'h0);
    chk_out(1, op_invert_imm, 1, 4'h2, 32'h7fffffff, 4'he, 4'h2, 0, 0);
    send(32'hf07503f0, 1, 1, 0, 1, 32'h5, 32'h0);
    cmp({28'h0, opnd_addr}, 32'h5);
    chk_out(1, op_or_compl_imm, 1, 4'h3, 32'hffffff0f, 4'he, 4'ha, 0, 0);
    send(32'hf0750ff0, 1, 1, 0, 1, 32'h5, 32'h0);
    chk_out(1, op_or_compl_imm, 0, 4'h0, 32'h0, 4'h0, 4'h0, 1, 0);
    send(32'hf07d03f0, 1, 1, 0, 1, 32'h5, 32'h0);
    chk_out(1, op_or_compl_imm, 0, 4'h0, 32'h0, 4'h0, 4'h0, 1, 0);
  endtask

  // Negate of the most negative value and of zero.
  task automatic t_negate;
    send(32'h4248, 0, 1, 0, 0, 32'h0, 32'h80000000);
    chk_out(1, op_negate, 1, 4'h0, 32'h80000000, 4'hf, 4'h9, 0, 0);
    send(32'h4248, 0, 1, 0, 0, 32'h0, 32'h0);
    chk_out(1, op_negate, 1, 4'h0, 32'h0, 4'hf, 4'h6, 0, 0);
  endtask

  // Hints of both widths, a failed condition, a foreign opcode, then idle.
  task automatic t_quiet;
    send(32'hbf00, 0, 1, 0, 1, 32'h0, 32'h0);
    chk_out(1, op_hint, 0, 4'h0, 32'h0, 4'h0, 4'h0, 0, 0);
    send(32'hf3af8000, 1, 1, 0, 1, 32'h0, 32'h0);
    chk_out(1, op_hint, 0, 4'h0, 32'h0, 4'h0, 4'h0, 0, 0);
    send(32'h43d7, 0, 0, 0, 1, 32'h0, 32'h1);
    chk_out(1, op_invert_reg, 0, 4'h0, 32'h0, 4'h0, 4'h0, 0, 0);
    send(32'h4000, 0, 1, 0, 1, 32'h0, 32'h1);
    chk_out(0, op_none, 0, 4'h0, 32'h0, 4'h0, 4'h0, 0, 1);
    idle();
    chk_out(0, op_none, 0, 4'h0, 32'h0, 4'h0, 4'h0, 0, 0);
  endtask

  // Reset in mid-run clears the held result.
  task automatic t_reset;
    send(32'h43d7, 0, 1, 0, 1, 32'h0, 32'h1);
    instr_valid = 1'b0;
    rst_n = 1'b0;
    #2;
    cmp(rd_data, 32'h0);
    @(posedge clock);
    #1;
    rst_n = 1'b1;
    idle();
    chk_out(0, op_none, 0, 4'h0, 32'h0, 4'h0, 4'h0, 0, 0);
    send(32'h43d7, 0, 1, 0, 1, 32'h0, 32'h1);
    chk_out(1, op_invert_reg, 1, 4'h7, 32'hfffffffe, 4'he, 4'ha, 0, 0);
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic end_sim;
    $display("Comparisons %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Main sequence.
  initial
  begin
    clock = 1'b0;
    rst_n = 1'b0;
    n_mismatch = 0;
    checks = 0;
    send(32'h0, 0, 0, 0, 0, 32'h0, 32'h0);
    instr_valid = 1'b0;
    repeat (10) @(posedge clock);
    #1;
    rst_n = 1'b1;
    t_narrow();
    t_wide();
    t_imm();
    t_negate();
    t_quiet();
    t_reset();
    end_sim();
  end

  // Cuts a hang short well beyond the expected run length.
  initial
  begin
    #5000;
    n_mismatch++;
    end_sim();
  end
endmodule

bind invert_group_exec invert_group_exec_sva u_sva (.clock(clock), .rst_n(rst_n),
  .instr_valid(instr_valid), .instr(instr), .instr_wide(instr_wide), .cond_passed(cond_passed),
  .in_conditional_block(in_conditional_block), .carry_flag(carry_flag), .opnd_data(opnd_data),
  .src_data(src_data), .opnd_addr(opnd_addr), .src_addr(src_addr), .retire(retire),
  .retired_op(retired_op), .decode_miss(decode_miss), .unpredictable(unpredictable),
  .rd_we(rd_we), .rd_addr(rd_addr), .rd_data(rd_data), .flags_we(flags_we),
  .flags_value(flags_value));
